// File: src/pinmx_device.sv
// Display controller end: reset straps, pin roles and strobe mapping
//
// Design decisions made here: the placing of the registers and the host bus register port.
`timescale 1ns/1ps
module pinmx_device
  import pinmx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  pinmx_if.device   lk,
  output logic      pixel_tick,
  output logic      hw_suspend
);
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_HOLD} pinmx_bus_t;
  typedef enum logic [1:0] {MEM_IDLE, MEM_ROW, MEM_COL, MEM_END} pinmx_mem_t;

  typedef struct packed {
    logic              rst_d;
    logic              ck_d;
    logic [15:0]       straps;
    logic [7:0]        memcfg;
    logic [7:0]        panel;
    logic [7:0]        clkcfg;
    logic [7:0]        gpio;
    logic [7:0]        genout;
    logic [7:0]        memaddr;
    logic [15:0]       memdat;
    logic [3:0]        cmd;
    pinmx_bus_t        bus;
    logic [2:0]        wcnt;
    pinmx_mem_t        mst;
    logic [1:0]        pdiv;
    logic [1:0]        mdiv;
    logic [2:0]        bias_cnt;
    logic              shift2;
    logic              bias;
    logic              wait_out;
    logic              wait_oe_n;
    logic [7:0]        rdata;
    logic              md_oe_n;
    logic              ras_n;
    logic              lo_strobe_n;
    logic              up_strobe_n;
    logic              we_n;
    logic [2:0]        ua_out;
    logic [2:0]        ua_oe_n;
    logic [15:0]       pdat;
    logic              ppwr;
    logic              pmulti;
    logic              susp_out;
    logic              susp_oe_n;
    logic              pix;
    logic              hws;
  } pinmx_dev_t;

  pinmx_dev_t s_r;
  pinmx_dev_t s_nxt;

  logic        rst_s;
  logic        clk_s;
  logic        cs_s;
  logic        rd_s;
  logic        we_s;
  logic        susp_s;
  logic [2:0]  ua_s;
  logic [15:0] md_s;
  logic [7:0]  addr_s;
  logic [7:0]  wdata_s;

  // Bus strobes and suspend level start idle high so no access is seen out of reset
  pinmx_sync #(.W(41), .RST(41'h078_0000_0000)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({lk.dev_reset_n, lk.input_clock_pin, lk.cs_n, lk.rd_n, lk.low_byte_write_in,
               lk.suspend_level, lk.mem_addr_bit_eleven, lk.mem_addr_bit_ten, lk.mem_addr_bit_nine,
               lk.memory_data_straps, lk.bus_addr, lk.bus_wdata}),
    .q       ({rst_s, clk_s, cs_s, rd_s, we_s, susp_s, ua_s, md_s, addr_s, wdata_s})
  );

  // Returns {enable, next count}: one enable every sel+1 rising input-clock edges
  function automatic logic [2:0] div_step(input logic [1:0] cnt, input logic [1:0] sel, input logic tick);
    if (!tick)
      return {1'b0, cnt};
    if (cnt == sel)
      return 3'h4;
    return {1'b0, cnt + 2'h1};
  endfunction

  // Panel pins carrying data for each panel type; the rest stay low
  function automatic logic [15:0] pnl_mask(input logic [2:0] ptype);
    unique case (ptype)
      PNL_MONO4, PNL_COLOR4: return 16'h00F0;
      PNL_COLOR16:           return 16'hFFFF;
      PNL_TFT9:              return 16'h01FF;
      PNL_TFT18:             return 16'h4BFF;
      default:               return 16'h00FF;
    endcase
  endfunction

  logic       ctick;
  logic       pen;
  logic       men;
  logic       acc;
  logic       col;
  logic       pwr_on;
  logic [2:0] ua_addr;

  always_comb
  begin
    s_nxt = s_r;
    ctick = 1'b0;
    pen = 1'b0;
    men = 1'b0;
    acc = 1'b0;
    col = 1'b0;
    pwr_on = 1'b0;
    ua_addr = 3'h0;
    s_nxt.rst_d = rst_s;
    s_nxt.ck_d = clk_s;
    if (!rst_s)
    begin
      // Registers cleared; strobes high, shared pins released except the suspend pin when strapped as output
      s_nxt = '0;
      s_nxt.wait_oe_n = 1'b1;
      s_nxt.md_oe_n = 1'b1;
      s_nxt.ras_n = 1'b1;
      s_nxt.lo_strobe_n = 1'b1;
      s_nxt.up_strobe_n = 1'b1;
      s_nxt.we_n = 1'b1;
      s_nxt.ua_oe_n = 3'h7;
      s_nxt.ppwr = md_s[STRAP_PWR_POL];
      s_nxt.susp_oe_n = ~md_s[STRAP_SUSP_FN];
      s_nxt.susp_out = ~md_s[STRAP_PWR_POL];
      s_nxt.ck_d = clk_s;
    end
    else
    begin
      if (!s_r.rst_d)
        s_nxt.straps = md_s;
      ctick = clk_s & ~s_r.ck_d;
      {pen, s_nxt.pdiv} = div_step(s_r.pdiv, s_r.clkcfg[1:0], ctick);
      {men, s_nxt.mdiv} = div_step(s_r.mdiv, s_r.clkcfg[5:4], ctick);

      // DRAM cycle paced by the memory clock enable
      if (men)
      begin
        unique case (s_r.mst)
          MEM_IDLE:
            if (s_r.cmd[CMD_GO])
            begin
              s_nxt.mst = MEM_ROW;
              s_nxt.cmd[CMD_GO] = 1'b0;
            end
          MEM_ROW: s_nxt.mst = MEM_COL;
          MEM_COL:
          begin
            s_nxt.mst = MEM_END;
            if (!s_r.cmd[CMD_WR])
              s_nxt.memdat = md_s;
          end
          MEM_END: s_nxt.mst = MEM_IDLE;
        endcase
      end

      // Host access; register write after the memory update so software wins a tie
      acc = ~cs_s & (~rd_s | ~we_s);
      unique case (s_r.bus)
        BUS_IDLE:
          if (acc)
          begin
            s_nxt.bus = BUS_WAIT;
            s_nxt.wcnt = WAIT_CYCLES - 3'h1;
          end
        BUS_WAIT:
          if (s_r.wcnt != 3'h0)
            s_nxt.wcnt = s_r.wcnt - 3'h1;
          else
          begin
            s_nxt.bus = BUS_HOLD;
            if (!we_s)
            begin
              unique case (addr_s)
                REG_MEMCFG:    s_nxt.memcfg = wdata_s;
                REG_PANEL:     s_nxt.panel = wdata_s;
                REG_MEMCMD:    s_nxt.cmd = wdata_s[3:0];
                REG_MEMDAT_LO: s_nxt.memdat[7:0] = wdata_s;
                REG_MEMDAT_HI: s_nxt.memdat[15:8] = wdata_s;
                REG_MEMADDR:   s_nxt.memaddr = wdata_s;
                REG_CLKCFG:    s_nxt.clkcfg = wdata_s;
                REG_GPIO:      s_nxt.gpio = wdata_s;
                REG_GENOUT:    s_nxt.genout = wdata_s;
                default:       s_nxt.bus = BUS_HOLD;
              endcase
            end
            else
            begin
              unique case (addr_s)
                REG_STATUS:    s_nxt.rdata = {2'h0, s_r.ppwr, ua_s, s_r.hws, s_r.mst != MEM_IDLE};
                REG_MEMCFG:    s_nxt.rdata = s_r.memcfg;
                REG_PANEL:     s_nxt.rdata = s_r.panel;
                REG_STRAP_LO:  s_nxt.rdata = s_r.straps[7:0];
                REG_STRAP_HI:  s_nxt.rdata = s_r.straps[15:8];
                REG_MEMCMD:    s_nxt.rdata = {4'h0, s_r.cmd};
                REG_MEMDAT_LO: s_nxt.rdata = s_r.memdat[7:0];
                REG_MEMDAT_HI: s_nxt.rdata = s_r.memdat[15:8];
                REG_MEMADDR:   s_nxt.rdata = s_r.memaddr;
                REG_CLKCFG:    s_nxt.rdata = s_r.clkcfg;
                REG_GPIO:      s_nxt.rdata = s_r.gpio;
                REG_GENOUT:    s_nxt.rdata = s_r.genout;
                default:       s_nxt.rdata = REG_RESET;
              endcase
            end
          end
        BUS_HOLD:
          if (!acc)
            s_nxt.bus = BUS_IDLE;
        default: s_nxt.bus = BUS_IDLE;
      endcase

      // Strapped polarity only; never changes until the next reset
      s_nxt.wait_oe_n = 1'b0;
      // Strap being latched this cycle, so no wrong-polarity pulse follows reset
      s_nxt.wait_out = (s_nxt.bus == BUS_WAIT) ? s_nxt.straps[STRAP_WAIT_POL] : ~s_nxt.straps[STRAP_WAIT_POL];

      col = s_nxt.mst == MEM_COL;
      s_nxt.ras_n = ~(s_nxt.mst == MEM_ROW || col);
      s_nxt.md_oe_n = ~(~s_nxt.ras_n & s_nxt.cmd[CMD_WR]);
      if (s_r.memcfg[MEMCFG_DUAL])
      begin
        s_nxt.lo_strobe_n = ~(col & s_nxt.cmd[CMD_LO]);
        s_nxt.up_strobe_n = ~(col & s_nxt.cmd[CMD_HI]);
        s_nxt.we_n = ~(col & s_nxt.cmd[CMD_WR]);
      end
      else
      begin
        s_nxt.lo_strobe_n = ~col;
        s_nxt.up_strobe_n = ~(col & s_nxt.cmd[CMD_WR] & s_nxt.cmd[CMD_HI]);
        s_nxt.we_n = ~(col & s_nxt.cmd[CMD_WR] & s_nxt.cmd[CMD_LO]);
      end

      // Shared upper address pins: address role by memory map, else GPIO
      ua_addr[0] = s_r.straps[7:6] != MAP_SYM_512K;
      ua_addr[1] = s_r.straps[7:6] == MAP_ASYM_2M;
      ua_addr[2] = s_r.straps[7:6] == MAP_ASYM_2M;
      for (int i = 0; i < 3; i++)
      begin
        s_nxt.ua_oe_n[i] = ua_addr[i] ? 1'b0 : ~s_r.gpio[i];
        s_nxt.ua_out[i] = ua_addr[i] ? 1'b0 : s_r.gpio[GPIO_OUT_LO + i];
      end

      if (!s_r.straps[STRAP_SUSP_FN])
      begin
        s_nxt.susp_oe_n = 1'b1;
        s_nxt.hws = ~susp_s;
      end
      else
      begin
        s_nxt.susp_oe_n = 1'b0;
        s_nxt.susp_out = ~s_r.genout[GENOUT_BIT] ^ s_r.straps[STRAP_PWR_POL];
        s_nxt.hws = 1'b0;
      end

      pwr_on = ~s_r.memcfg[MEMCFG_PSAVE] & ~s_r.hws;
      s_nxt.ppwr = pwr_on ^ s_r.straps[STRAP_PWR_POL];
      s_nxt.pix = pen;
      if (pen)
      begin
        s_nxt.pdat = pwr_on ? (s_r.memdat & pnl_mask(s_r.panel[2:0])) : 16'h0000;
        s_nxt.shift2 = ~s_r.shift2;
        s_nxt.bias_cnt = s_r.bias_cnt + 3'h1;
        if (s_r.bias_cnt == BIAS_DIV)
          s_nxt.bias = ~s_r.bias;
      end
      // Multi pin: power level on TFT panels, shift2 on PNL_FMT1_8, else bias toggling while powered so the LCD sees no DC
      if (s_r.panel[2:0] == PNL_TFT9 || s_r.panel[2:0] == PNL_TFT18)
        s_nxt.pmulti = pwr_on;
      else if (s_r.panel[2:0] == PNL_FMT1_8)
        s_nxt.pmulti = s_nxt.shift2 & pwr_on;
      else
        s_nxt.pmulti = s_nxt.bias & pwr_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.wait_oe_n <= 1'b1;
      s_r.md_oe_n <= 1'b1;
      s_r.ras_n <= 1'b1;
      s_r.lo_strobe_n <= 1'b1;
      s_r.up_strobe_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.ua_oe_n <= 3'h7;
      s_r.susp_oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign lk.bus_rdata = s_r.rdata;
  assign lk.wait_out = s_r.wait_out;
  assign lk.wait_oe_n = s_r.wait_oe_n;
  assign lk.dev_md_out = s_r.memdat;
  assign lk.dev_md_oe_n = s_r.md_oe_n;
  assign lk.ras_n = s_r.ras_n;
  assign lk.lower_col_strobe = s_r.lo_strobe_n;
  assign lk.upper_col_strobe = s_r.up_strobe_n;
  assign lk.mem_write_n = s_r.we_n;
  assign lk.mem_addr = {1'b0, s_r.memaddr};
  assign lk.upper_addr_out = s_r.ua_out;
  assign lk.upper_addr_oe_n = s_r.ua_oe_n;
  assign lk.panel_data_out = s_r.pdat;
  assign lk.panel_power_ctl = s_r.ppwr;
  assign lk.panel_multi_pin = s_r.pmulti;
  assign lk.suspend_out = s_r.susp_out;
  assign lk.suspend_oe_n = s_r.susp_oe_n;
  assign pixel_tick = s_r.pix;
  assign hw_suspend = s_r.hws;
endmodule // pinmx_device

// File: src/pinmx_host.sv
// Host end: APB-controlled driver of reset, straps, clock and bus cycles
`timescale 1ns/1ps
module pinmx_host
  import pinmx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pinmx_if.host            lk
);
  typedef enum logic [1:0] {HB_IDLE, HB_ASSERT, HB_ACK, HB_GAP} pinmx_hbus_t;

  typedef struct packed {
    logic        rst_hold;
    logic [15:0] strap;
    logic [3:0]  hold;
    logic [1:0]  ccnt;
    logic        clk;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        rd;
    pinmx_hbus_t bus;
    logic [2:0]  gap;
    logic [7:0]  rdata;
    logic        susp_n;
    logic [2:0]  gpio;
    logic        test_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        md_oe_n;
  } pinmx_host_t;

  pinmx_host_t s_r;
  pinmx_host_t s_nxt;

  logic       wait_s;
  logic [7:0] rdata_s;
  logic       wait_act;
  logic       done;

  pinmx_sync #(.W(9), .RST(9'h000)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({lk.wait_level, lk.bus_rdata}),
    .q       ({wait_s, rdata_s})
  );

  always_comb
  begin
    s_nxt = s_r;
    wait_act = wait_s == s_r.strap[STRAP_WAIT_POL];
    done = psel & penable & s_r.pready;
    // Free-running divided clock towards the device
    s_nxt.ccnt = s_r.ccnt + 2'h1;
    if (s_r.ccnt == CLK_HALF)
    begin
      s_nxt.ccnt = 2'h0;
      s_nxt.clk = ~s_r.clk;
    end
    if (s_r.hold != 4'h0)
      s_nxt.hold = s_r.hold - 4'h1;

    unique case (s_r.bus)
      HB_IDLE: ;
      HB_ASSERT:
        if (wait_act)
          s_nxt.bus = HB_ACK;
      HB_ACK:
        if (!wait_act)
        begin
          s_nxt.bus = HB_GAP;
          s_nxt.gap = BUS_GAP;
          s_nxt.rdata = rdata_s;
        end
      HB_GAP:
        if (s_r.gap == 3'h0)
          s_nxt.bus = HB_IDLE;
        else
          s_nxt.gap = s_r.gap - 3'h1;
    endcase

    s_nxt.pready = psel & ~penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;
    if (psel & ~penable)
    begin
      unique case (paddr)
        H_CTRL:   s_nxt.prdata = {31'h0, s_r.rst_hold};
        H_STRAP:  s_nxt.prdata = {16'h0, s_r.strap};
        H_CMD:    s_nxt.prdata = {15'h0, s_r.rd, s_r.wdata, s_r.addr};
        H_STATUS: s_nxt.prdata = {23'h0, s_r.rdata, s_r.bus != HB_IDLE};
        H_PINS:   s_nxt.prdata = {27'h0, s_r.test_en, s_r.gpio, s_r.susp_n};
        default:  s_nxt.pslverr = 1'b1;
      endcase
    end
    if (done & pwrite)
    begin
      unique case (paddr)
        H_CTRL:
        begin
          if (s_r.rst_hold & ~pwdata[0])
            s_nxt.hold = STRAP_HOLD;
          s_nxt.rst_hold = pwdata[0];
        end
        H_STRAP: s_nxt.strap = pwdata[15:0];
        H_CMD:
          if (s_r.bus == HB_IDLE)
          begin
            s_nxt.addr = pwdata[7:0];
            s_nxt.wdata = pwdata[15:8];
            s_nxt.rd = pwdata[16];
            s_nxt.bus = HB_ASSERT;
          end
        H_PINS:
        begin
          s_nxt.susp_n = pwdata[0];
          s_nxt.gpio = pwdata[3:1];
          s_nxt.test_en = pwdata[4];
        end
        default: s_nxt.test_en = s_r.test_en;
      endcase
    end

    // Link strobes registered so the device never sees a decode glitch
    s_nxt.cs_n = ~(s_nxt.bus == HB_ASSERT || s_nxt.bus == HB_ACK);
    s_nxt.rd_n = s_nxt.cs_n | ~s_nxt.rd;
    s_nxt.wr_n = s_nxt.cs_n | s_nxt.rd;
    s_nxt.md_oe_n = ~(s_nxt.rst_hold | (s_nxt.hold != 4'h0));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.rst_hold <= 1'b1;
      s_r.susp_n <= 1'b1;
      s_r.cs_n <= 1'b1;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Active-high hold bit is inverted onto the active-low reset pin
  assign lk.dev_reset_n = ~s_r.rst_hold;
  assign lk.input_clock_pin = s_r.clk;
  assign lk.test_enable_pin = s_r.test_en;
  assign lk.cs_n = s_r.cs_n;
  assign lk.rd_n = s_r.rd_n;
  assign lk.low_byte_write_in = s_r.wr_n;
  assign lk.bus_addr = s_r.addr;
  assign lk.bus_wdata = s_r.wdata;
  // Straps stay driven a while after release; zero default suits ISA wait sense
  assign lk.host_md_out = s_r.strap;
  assign lk.host_md_oe_n = s_r.md_oe_n;
  assign lk.host_gpio_in = s_r.gpio;
  assign lk.host_suspend_n = s_r.susp_n;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
endmodule // pinmx_host

// File: src/pinmx_if.sv
// Interface: pins between the host side and the display controller
`timescale 1ns/1ps
interface pinmx_if;
  logic        dev_reset_n;
  logic        input_clock_pin;
  logic        test_enable_pin;
  logic        cs_n;
  logic        rd_n;
  logic        low_byte_write_in;
  logic [7:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        wait_out;
  logic        wait_oe_n;
  logic        wait_level;
  logic [15:0] host_md_out;
  logic        host_md_oe_n;
  logic [15:0] dev_md_out;
  logic        dev_md_oe_n;
  logic [15:0] memory_data_straps;
  logic        ras_n;
  logic        lower_col_strobe;
  logic        upper_col_strobe;
  logic        mem_write_n;
  logic [8:0]  mem_addr;
  logic [2:0]  upper_addr_out;
  logic [2:0]  upper_addr_oe_n;
  logic [2:0]  host_gpio_in;
  logic        mem_addr_bit_nine;
  logic        mem_addr_bit_ten;
  logic        mem_addr_bit_eleven;
  logic [15:0] panel_data_out;
  logic        panel_power_ctl;
  logic        panel_multi_pin;
  logic        suspend_out;
  logic        suspend_oe_n;
  logic        host_suspend_n;
  logic        suspend_level;

  // Undriven data and wait lines fall to the pull-down level
  assign memory_data_straps  = !host_md_oe_n ? host_md_out : (!dev_md_oe_n ? dev_md_out : 16'h0000);
  assign wait_level          = !wait_oe_n ? wait_out : 1'b0;
  assign suspend_level       = !suspend_oe_n ? suspend_out : host_suspend_n;
  assign mem_addr_bit_nine   = !upper_addr_oe_n[0] ? upper_addr_out[0] : host_gpio_in[0];
  assign mem_addr_bit_ten    = !upper_addr_oe_n[1] ? upper_addr_out[1] : host_gpio_in[1];
  assign mem_addr_bit_eleven = !upper_addr_oe_n[2] ? upper_addr_out[2] : host_gpio_in[2];

  modport device (
    input  dev_reset_n, input_clock_pin, test_enable_pin, cs_n, rd_n, low_byte_write_in,
    input  bus_addr, bus_wdata, memory_data_straps, suspend_level,
    input  mem_addr_bit_nine, mem_addr_bit_ten, mem_addr_bit_eleven,
    output bus_rdata, wait_out, wait_oe_n, dev_md_out, dev_md_oe_n, ras_n, lower_col_strobe,
    output upper_col_strobe, mem_write_n, mem_addr, upper_addr_out, upper_addr_oe_n,
    output panel_data_out, panel_power_ctl, panel_multi_pin, suspend_out, suspend_oe_n
  );
  modport host (
    output dev_reset_n, input_clock_pin, test_enable_pin, cs_n, rd_n, low_byte_write_in,
    output bus_addr, bus_wdata, host_md_out, host_md_oe_n, host_gpio_in, host_suspend_n,
    input  bus_rdata, wait_level
  );
endinterface

// File: src/pinmx_pkg.sv
// Package: shared constants for the pin strap and pin mux block
package pinmx_pkg;
  // Strap positions on the memory data pins
  localparam int STRAP_W        = 16;
  localparam int STRAP_WAIT_POL = 5;
  localparam int STRAP_MAP_LO   = 6;
  localparam int STRAP_SUSP_FN  = 9;
  localparam int STRAP_PWR_POL  = 10;
  // Memory map straps [7:6]
  localparam logic [1:0] MAP_SYM_512K = 2'h0;
  localparam logic [1:0] MAP_ASYM_2M  = 2'h3;
  // Device registers, byte offsets on the host bus
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_MEMCFG    = 8'h01;
  localparam logic [7:0] REG_PANEL     = 8'h02;
  localparam logic [7:0] REG_STRAP_LO  = 8'h03;
  localparam logic [7:0] REG_STRAP_HI  = 8'h04;
  localparam logic [7:0] REG_MEMCMD    = 8'h10;
  localparam logic [7:0] REG_MEMDAT_LO = 8'h11;
  localparam logic [7:0] REG_MEMDAT_HI = 8'h12;
  localparam logic [7:0] REG_MEMADDR   = 8'h13;
  localparam logic [7:0] REG_CLKCFG    = 8'h19;
  localparam logic [7:0] REG_GPIO      = 8'h20;
  localparam logic [7:0] REG_GENOUT    = 8'h21;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Field positions
  localparam int MEMCFG_DUAL  = 0;
  localparam int MEMCFG_PSAVE = 1;
  localparam int CMD_GO       = 0;
  localparam int CMD_WR       = 1;
  localparam int CMD_HI       = 2;
  localparam int CMD_LO       = 3;
  localparam int GPIO_OUT_LO  = 4;
  localparam int GENOUT_BIT   = 7;
  // Panel types in REG_PANEL[2:0]
  localparam logic [2:0] PNL_MONO4   = 3'h0;
  localparam logic [2:0] PNL_SINGLE8 = 3'h1;
  localparam logic [2:0] PNL_DUAL8   = 3'h2;
  localparam logic [2:0] PNL_COLOR4  = 3'h3;
  localparam logic [2:0] PNL_FMT1_8  = 3'h4;
  localparam logic [2:0] PNL_COLOR16 = 3'h5;
  localparam logic [2:0] PNL_TFT9    = 3'h6;
  localparam logic [2:0] PNL_TFT18   = 3'h7;
  // Cycle counts
  localparam logic [2:0] WAIT_CYCLES = 3'h4;
  localparam logic [2:0] BIAS_DIV    = 3'h7;
  localparam logic [1:0] CLK_HALF    = 2'h1;
  localparam logic [3:0] STRAP_HOLD  = 4'h8;
  localparam logic [2:0] BUS_GAP     = 3'h4;
  // Host controller registers on APB
  localparam logic [7:0] H_CTRL   = 8'h00;
  localparam logic [7:0] H_STRAP  = 8'h04;
  localparam logic [7:0] H_CMD    = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0C;
  localparam logic [7:0] H_PINS   = 8'h10;
endpackage

// File: src/pinmx_sync.sv
// Two flip-flop synchroniser for levels entering the pclk domain
`timescale 1ns/1ps
module pinmx_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } pinmx_sync_t;

  pinmx_sync_t s_r;
  pinmx_sync_t s_nxt;

  always_comb
  begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= {RST, RST};
    else
      s_r <= s_nxt;
  end

  assign q = s_r.stab;
endmodule // pinmx_sync

// File: testbench/pinmx_properties.sv
// Checker of strap, pin role and strobe relations on the link
`timescale 1ns/1ps
module pinmx_properties
  import pinmx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        dev_reset_n,
  input wire logic        ras_n,
  input wire logic        lower_col_strobe,
  input wire logic        mem_write_n,
  input wire logic        wait_out,
  input wire logic        wait_oe_n,
  input wire logic [15:0] memory_data_straps,
  input wire logic [2:0]  upper_addr_oe_n,
  input wire logic        suspend_out,
  input wire logic        suspend_oe_n
);
  logic [15:0] md;
  assign md = memory_data_straps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Host holds the straps eight clocks after the pin rises, so they can still be compared
  strobes_idle_a: assert property (!dev_reset_n [*4] |-> ras_n && lower_col_strobe && mem_write_n)
    else $error("strobe low in reset");
  wait_float_a: assert property (!dev_reset_n [*4] |-> wait_oe_n)
    else $error("wait driven in reset");
  col_in_row_a: assert property (!lower_col_strobe |-> !ras_n)
    else $error("column strobe alone");
  write_in_row_a: assert property (!mem_write_n |-> !ras_n)
    else $error("write strobe alone");
  addr_role_a: assert property ($rose(dev_reset_n) ##6 1 |->
    upper_addr_oe_n == {{2{md[7:6] != MAP_ASYM_2M}}, md[7:6] == MAP_SYM_512K})
    else $error("address pin role");
  susp_role_a: assert property ($rose(dev_reset_n) ##6 1 |-> suspend_oe_n == !md[9])
    else $error("suspend pin role");
  gpo_reset_a: assert property ($rose(dev_reset_n) ##6 !suspend_oe_n |-> suspend_out == !md[10])
    else $error("output reset level");
  wait_idle_a: assert property ($rose(dev_reset_n) ##7 1 |-> wait_oe_n || wait_out == !md[5])
    else $error("wait idle level");
endmodule // pinmx_properties

// File: testbench/pinmx_test.sv
// Testbench: APB host end driving the device end
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %0t mismatch", $time); end end
module pinmx_test
  import pinmx_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        pix;
  logic        hws;
  logic [7:0]  ticks;
  logic [15:0] tbl [3] = '{16'h06E0, 16'h0260, 16'h0000};
  int          num_errors = 0;
  int          checks_done = 0;
  pinmx_if lk ();
  always #12.5 pclk = ~pclk;
  pinmx_host u_pinmx_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(lk));
  pinmx_device u_pinmx_device (.pclk(pclk), .presetn(presetn), .lk(lk), .pixel_tick(pix), .hw_suspend(hws));
  pinmx_properties u_pinmx_properties (.pclk(pclk), .presetn(presetn), .dev_reset_n(lk.dev_reset_n),
    .ras_n(lk.ras_n), .lower_col_strobe(lk.lower_col_strobe), .mem_write_n(lk.mem_write_n),
    .wait_out(lk.wait_out), .wait_oe_n(lk.wait_oe_n), .memory_data_straps(lk.memory_data_straps),
    .upper_addr_oe_n(lk.upper_addr_oe_n), .suspend_out(lk.suspend_out), .suspend_oe_n(lk.suspend_oe_n));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic dev(input logic r, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, H_CMD, {15'h0000, r, d, a});
    do
      apb(1'b0, H_STATUS, 32'h00000000);
    while (rd[0] !== 1'b0);
  endtask
  task automatic count_ticks(output logic [7:0] cnt);
    cnt = 8'h00;
    repeat (40)
    begin
      @(posedge pclk);
      cnt += pix;
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(lk.ras_n & lk.lower_col_strobe & lk.upper_col_strobe & lk.mem_write_n, 1'b1)
    apb(1'b0, 8'h40, 32'h00000000);
    `CHK(err, 1'b1)
    foreach (tbl[i])
    begin
      apb(1'b1, H_CTRL, 32'h00000001);
      apb(1'b1, H_STRAP, {16'h0000, tbl[i]});
      apb(1'b1, H_CTRL, 32'h00000000);
      // Device ignores its bus until the link reset has settled
      repeat (40) @(posedge pclk);
      `CHK(lk.panel_data_out & 16'hFF0F, 16'h0000)
      `CHK(lk.panel_power_ctl, ~tbl[i][10])
      dev(1'b0, REG_MEMCMD, 8'h0B);
      dev(1'b1, REG_STRAP_LO, 8'h00);
      `CHK(rd[8:1], tbl[i][7:0])
      dev(1'b1, REG_STRAP_HI, 8'h00);
      `CHK(rd[8:1], tbl[i][15:8])
      dev(1'b0, REG_GENOUT, 8'h80);
      `CHK(lk.suspend_oe_n | (lk.suspend_level == tbl[i][10]), 1'b1)
    end
    // Last strap set: symmetric small map, suspend pin as input
    dev(1'b0, REG_MEMDAT_LO, 8'hFF);
    dev(1'b0, REG_MEMDAT_HI, 8'hFF);
    count_ticks(ticks);
    `CHK(lk.panel_data_out, 16'h00F0)
    `CHK(ticks, 40 / (2 * (CLK_HALF + 1)))
    dev(1'b0, REG_PANEL, 8'h07);
    dev(1'b0, REG_CLKCFG, 8'h01);
    count_ticks(ticks);
    `CHK(lk.panel_data_out, 16'h4BFF)
    `CHK(lk.panel_multi_pin, 1'b1)
    `CHK(ticks, 40 / (4 * (CLK_HALF + 1)))
    dev(1'b0, REG_GPIO, 8'h11);
    `CHK(lk.upper_addr_oe_n, 3'h6)
    `CHK(lk.mem_addr_bit_nine, 1'b1)
    apb(1'b1, H_PINS, 32'h00000000);
    repeat (8) @(posedge pclk);
    `CHK(hws, 1'b1)
    `CHK(lk.panel_power_ctl, 1'b0)
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    final_report();
  end
endmodule // pinmx_test
